// ===== rtl/cmsa_defines.svh
/*
 constants for the chip memory slot arbiter: line timing, slot budget, blit cycle lengths.
 assumes inclusion by bare name from the arbiter and the bench.
*/
`ifndef CMSA_DEFINES_SVH
`define CMSA_DEFINES_SVH
`define CMSA_SLOTS_PER_LINE   8'd227
`define CMSA_ALLOC_SLOTS      8'd226
`define CMSA_TICKS_PER_SLOT   2'd2
`define CMSA_REFRESH_SLOTS    4
`define CMSA_DISK_SLOTS       3
`define CMSA_AUDIO_SLOTS      4
`define CMSA_SPRITE_SLOTS     16
`define CMSA_REFRESH_FIRST    8'h01
`define CMSA_DISK_FIRST       8'h09
`define CMSA_AUDIO_FIRST      8'h0F
`define CMSA_SPRITE_FIRST     8'h17
`define CMSA_BLIT_MIN_TICKS   4'd4
`define CMSA_BLIT_MAX_TICKS   4'd8
`define CMSA_BLIT_B_TICKS     4'd2
`define CMSA_BLIT_CD_TICKS    4'd2
`define CMSA_LINE_PIXEL_TICKS 4'd8
`define CMSA_HOG_STARVE_LIMIT 2'd3
`endif

// ===== rtl/cmsa_pkg.sv
/*
 types for the chip memory slot arbiter.
 assumes cmsa_defines.svh supplies the numeric constants.
*/
package cmsa_pkg;
   typedef enum logic [2:0] {
      CMSA_GNT_NONE    = 3'b000,
      CMSA_GNT_REFRESH = 3'b001,
      CMSA_GNT_FIXED   = 3'b010,
      CMSA_GNT_PLANE   = 3'b011,
      CMSA_GNT_COPROC  = 3'b100,
      CMSA_GNT_BLIT    = 3'b101,
      CMSA_GNT_HOST    = 3'b110
   } cmsa_grant_e;

   typedef enum logic [1:0] {
      CMSA_BL_IDLE = 2'b00,
      CMSA_BL_RUN  = 2'b01,
      CMSA_BL_DONE = 2'b10
   } cmsa_blit_state_e;

   typedef struct packed {
      logic disk;
      logic audio;
      logic sprite;
      logic plane;
      logic coproc;
      logic blit;
      logic host;
   } cmsa_req_s;

   typedef struct packed {
      logic src_a;
      logic src_b;
      logic src_c;
      logic dst_d;
      logic line_mode;
   } cmsa_blit_cfg_s;
endpackage : cmsa_pkg

// ===== rtl/cmsa_arbiter.sv
/*
 chip memory slot arbiter: per-line slot counter, fixed slot groups, priority grant,
 blit hog/yield control and blit cycle length timer.
 assumes requests are synchronous to clk, that the host never issues indivisible
 read-modify-write cycles and that it stalls itself while not granted.
*/
`timescale 1ns/1ns
`include "cmsa_defines.svh"

// How it works
// - blit cycle length counts only enabled channels, clamped between four and eight ticks
// - first source channel adds nothing; second source channel adds two ticks
// - third source or destination alone free; both together add two ticks
// - line mode spends eight ticks per pixel
// - blit total equals ticks per cycle times height times width
// - disk, audio, display and sprite share top priority in fixed slot groups
// - bit-plane fetches beat sprite fetches in shared slots
// - unused fixed slots are offered to lower-priority requesters
// - coprocessor below fixed channels, then blit engine, host lowest
// - line has 227.5 slots of 280 ns, 226 allocatable
// - refresh 4, disk 3, audio 4, sprite 16, planes per display size
// - host gets only even-numbered slots
// - up to four lowres planes leave alternate slots to the host
// - six lowres planes use 120 slots per line
// - four hires planes take every display slot, locking out lower requesters
// - 20 or 40 words per plane per line, one more when scrolling
// - blit engine never takes slots from display, disk or audio
// - priority bit set: blit keeps every slot available to it
// - priority bit clear: after three starved host slots blit yields one
// - blit outranks host by default, sharing only while the priority bit is clear
module cmsa_arbiter (
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire cmsa_pkg::cmsa_req_s    req,
   input  wire logic                   plane_slot,
   input  wire logic                   blit_bus_priority_bit,
   input  wire cmsa_pkg::cmsa_blit_cfg_s blit_cfg,
   input  wire logic                   blit_start,
   input  wire logic [9:0]             blit_height,
   input  wire logic [5:0]             blit_width,
   output cmsa_pkg::cmsa_grant_e       grant,
   output logic                        grant_fixed_disk,
   output logic                        grant_fixed_audio,
   output logic                        grant_fixed_sprite,
   output logic                        slot_strobe,
   output logic [7:0]                  slot_index,
   output logic                        blit_busy,
   output logic [3:0]                  blit_cycle_ticks,
   output logic                        blit_cycle_done
);

   logic                      tick_phase;
   logic                      half_slot;
   logic [7:0]                slot;
   logic [1:0]                starve;
   logic [3:0]                tick_cnt;
   logic [15:0]               words_left;
   cmsa_pkg::cmsa_blit_state_e blit_state;
   cmsa_pkg::cmsa_grant_e     next_grant;
   logic                      next_disk;
   logic                      next_audio;
   logic                      next_sprite;
   logic                      host_asks;
   logic                      blit_wins;

   function automatic logic in_group(input logic [7:0] s, input logic [7:0] first, input int n);
      logic [8:0] off;
      off = {1'b0, s} - {1'b0, first};
      in_group = (s >= first) && (off < 9'(2 * n)) && !off[0];
   endfunction : in_group

   // trade-off: length is fixed at start; channel enables changed mid-blit are ignored
   function automatic logic [3:0] cycle_len(input cmsa_pkg::cmsa_blit_cfg_s c);
      logic [3:0] t;
      t = `CMSA_BLIT_MIN_TICKS;
      if (c.src_b)
         t = t + `CMSA_BLIT_B_TICKS;
      if (c.src_c && c.dst_d)
         t = t + `CMSA_BLIT_CD_TICKS;
      if (c.line_mode)
         t = `CMSA_LINE_PIXEL_TICKS;
      if (t > `CMSA_BLIT_MAX_TICKS)
         t = `CMSA_BLIT_MAX_TICKS;
      cycle_len = t;
   endfunction : cycle_len

   // one slot is two system ticks; the half slot at line end is absorbed every other line
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_phase <= 1'b0;
         slot       <= 8'h00;
         half_slot  <= 1'b0;
      end else begin
         tick_phase <= ~tick_phase;
         if (tick_phase) begin
            if (slot == `CMSA_SLOTS_PER_LINE - 8'd1 + {7'h00, half_slot}) begin
               slot      <= 8'h00;
               half_slot <= ~half_slot;
            end else begin
               slot <= slot + 8'd1;
            end
         end
      end
   end

   always_comb begin
      next_disk   = 1'b0;
      next_audio  = 1'b0;
      next_sprite = 1'b0;
      next_grant  = cmsa_pkg::CMSA_GNT_NONE;
      host_asks   = req.host && !slot[0] && slot < `CMSA_ALLOC_SLOTS;
      blit_wins   = req.blit && (blit_bus_priority_bit || starve != `CMSA_HOG_STARVE_LIMIT
                    || !host_asks);
      if (in_group(slot, `CMSA_REFRESH_FIRST, `CMSA_REFRESH_SLOTS)) begin
         next_grant = cmsa_pkg::CMSA_GNT_REFRESH;
      end else if (in_group(slot, `CMSA_DISK_FIRST, `CMSA_DISK_SLOTS) && req.disk) begin
         next_grant = cmsa_pkg::CMSA_GNT_FIXED;
         next_disk  = 1'b1;
      end else if (in_group(slot, `CMSA_AUDIO_FIRST, `CMSA_AUDIO_SLOTS) && req.audio) begin
         next_grant = cmsa_pkg::CMSA_GNT_FIXED;
         next_audio = 1'b1;
      end else if (plane_slot && req.plane) begin
         next_grant = cmsa_pkg::CMSA_GNT_PLANE;
      end else if (in_group(slot, `CMSA_SPRITE_FIRST, `CMSA_SPRITE_SLOTS) && req.sprite) begin
         next_grant  = cmsa_pkg::CMSA_GNT_FIXED;
         next_sprite = 1'b1;
      end else if (req.coproc && slot < `CMSA_ALLOC_SLOTS) begin
         next_grant = cmsa_pkg::CMSA_GNT_COPROC;
      end else if (blit_wins && blit_state == cmsa_pkg::CMSA_BL_RUN
                   && slot < `CMSA_ALLOC_SLOTS) begin
         next_grant = cmsa_pkg::CMSA_GNT_BLIT;
      end else if (host_asks) begin
         next_grant = cmsa_pkg::CMSA_GNT_HOST;
      end
   end

   // grant is registered once per slot, on the first tick of the slot
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         grant              <= cmsa_pkg::CMSA_GNT_NONE;
         grant_fixed_disk   <= 1'b0;
         grant_fixed_audio  <= 1'b0;
         grant_fixed_sprite <= 1'b0;
         slot_strobe        <= 1'b0;
         slot_index         <= 8'h00;
      end else begin
         slot_strobe <= ~tick_phase;
         if (!tick_phase) begin
            grant              <= next_grant;
            grant_fixed_disk   <= next_disk;
            grant_fixed_audio  <= next_audio;
            grant_fixed_sprite <= next_sprite;
            slot_index         <= slot;
         end
      end
   end

   // starved host slots; the yield slot resets the count
   // odd slots hold the count: clearing there would keep the host starved forever
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         starve <= 2'd0;
      end else if (!tick_phase) begin
         if (!req.host || next_grant == cmsa_pkg::CMSA_GNT_HOST)
            starve <= 2'd0;
         else if (host_asks && starve != `CMSA_HOG_STARVE_LIMIT)
            starve <= starve + 2'd1;
      end
   end

   // blit timer: a cycle starts only on a slot the blit engine owns, then advances every tick to its end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         blit_state       <= cmsa_pkg::CMSA_BL_IDLE;
         tick_cnt         <= 4'h0;
         words_left       <= 16'h0000;
         blit_cycle_ticks <= 4'h0;
         blit_cycle_done  <= 1'b0;
         blit_busy        <= 1'b0;
      end else begin
         blit_cycle_done <= 1'b0;
         case (blit_state)
            cmsa_pkg::CMSA_BL_IDLE: begin
               if (blit_start) begin
                  blit_cycle_ticks <= cycle_len(blit_cfg);
                  tick_cnt         <= 4'h0;
                  words_left       <= 16'({6'h00, blit_height} * {10'h000, blit_width});
                  blit_busy        <= 1'b1;
                  blit_state       <= cmsa_pkg::CMSA_BL_RUN;
               end
            end
            cmsa_pkg::CMSA_BL_RUN: begin
               if (words_left == 16'h0000) begin
                  blit_state <= cmsa_pkg::CMSA_BL_DONE;
               end else if (grant == cmsa_pkg::CMSA_GNT_BLIT || tick_cnt != 4'h0) begin
                  if (tick_cnt == blit_cycle_ticks - 4'h1) begin
                     tick_cnt        <= 4'h0;
                     words_left      <= words_left - 16'h0001;
                     blit_cycle_done <= 1'b1;
                  end else begin
                     tick_cnt <= tick_cnt + 4'h1;
                  end
               end
            end
            cmsa_pkg::CMSA_BL_DONE: begin
               blit_busy  <= 1'b0;
               blit_state <= cmsa_pkg::CMSA_BL_IDLE;
            end
            default: blit_state <= cmsa_pkg::CMSA_BL_IDLE;
         endcase
      end
   end
endmodule : cmsa_arbiter

// ===== bench/cmsa_monitor.sv
/* port checker for cmsa_arbiter, bound to every instance.
 assumes cmsa_pkg is compiled first. */
`timescale 1ns/1ns
module cmsa_monitor (
   input wire logic                  clk,
   input wire logic                  sys_rst,
   input wire cmsa_pkg::cmsa_req_s   req,
   input wire logic                  blit_bus_priority_bit,
   input wire cmsa_pkg::cmsa_grant_e grant,
   input wire logic                  grant_fixed_disk,
   input wire logic                  grant_fixed_audio,
   input wire logic                  grant_fixed_sprite,
   input wire logic                  slot_strobe,
   input wire logic [7:0]            slot_index,
   input wire logic                  blit_busy,
   input wire logic [3:0]            blit_cycle_ticks,
   input wire logic                  blit_cycle_done
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic fx;
   assign fx = grant == cmsa_pkg::CMSA_GNT_FIXED;
   host_even_a: assert property (grant == cmsa_pkg::CMSA_GNT_HOST |-> !slot_index[0] && slot_index < 8'hE2)
      else $error("host on odd or late slot");
   refresh_slot_a: assert property (slot_strobe && slot_index inside {8'h01, 8'h03, 8'h05, 8'h07}
      |-> grant == cmsa_pkg::CMSA_GNT_REFRESH) else $error("refresh slot lost");
   disk_slot_a: assert property (grant_fixed_disk |-> fx && slot_index inside {8'h09, 8'h0B, 8'h0D})
      else $error("disk grant off its slots");
   audio_group_a: assert property (grant_fixed_audio |-> fx && slot_index[0] && slot_index inside {[15:21]})
      else $error("audio grant off its slots");
   sprite_group_a: assert property (grant_fixed_sprite |-> fx && slot_index[0] && slot_index inside {[23:53]})
      else $error("sprite grant off its slots");
   grant_stands_a: assert property (slot_strobe |=> !slot_strobe && $stable(grant) ##1 slot_strobe)
      else $error("slot not two clocks");
   late_slot_a: assert property (slot_strobe && slot_index > 8'hE1 |-> grant < cmsa_pkg::CMSA_GNT_COPROC)
      else $error("late slot given away");
   blit_ticks_a: assert property (blit_busy |-> blit_cycle_ticks inside {[4:8]})
      else $error("blit cycle length out of range");
   hog_keep_a: assert property (slot_strobe && grant == cmsa_pkg::CMSA_GNT_HOST
      |-> !($past(blit_bus_priority_bit) && $past(req.blit) && $past(blit_busy))) else $error("host beat hog blit");
   coproc_first_a: assert property (slot_strobe && grant == cmsa_pkg::CMSA_GNT_BLIT |-> !$past(req.coproc))
      else $error("blit beat coprocessor");
   cover property (grant == cmsa_pkg::CMSA_GNT_HOST);
   cover property (grant == cmsa_pkg::CMSA_GNT_PLANE);
   cover property (blit_cycle_done);
endmodule : cmsa_monitor

bind cmsa_arbiter cmsa_monitor u_mon (.*);

// ===== bench/cmsa_host_model.sv
/* host processor stand-in: asks for the bus while enabled.
 assumes grant and slot_strobe come from the arbiter. */
`timescale 1ns/1ns
module cmsa_host_model (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire logic                  enable,
   input  wire logic                  slot_strobe,
   input  wire cmsa_pkg::cmsa_grant_e grant,
   output logic                       host_req
);
   // request held through missed and odd slots, taken only when granted
   // one plain access per slot, never a locked pair; pause a clock after service
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) host_req <= 1'b0;
      else host_req <= enable && !(slot_strobe && grant == cmsa_pkg::CMSA_GNT_HOST);
   end
endmodule : cmsa_host_model

// ===== bench/chip_memory_slot_arbiter_tb.sv
/* bench for cmsa_arbiter: fixed slots, priority, blit length, hog modes.
 assumes the host model stands in for the processor. */
`timescale 1ns/1ns
`include "cmsa_defines.svh"
module chip_memory_slot_arbiter_tb;
   logic                     clk, sys_rst, plane_slot, blit_bus_priority_bit, blit_start, host_en, host_req;
   logic                     grant_fixed_disk, grant_fixed_audio, grant_fixed_sprite, slot_strobe;
   logic                     blit_busy, blit_cycle_done;
   logic [9:0]               blit_height;
   logic [5:0]               blit_width;
   logic [7:0]               slot_index;
   logic [3:0]               blit_cycle_ticks;
   cmsa_pkg::cmsa_req_s      rq;
   cmsa_pkg::cmsa_blit_cfg_s blit_cfg;
   cmsa_pkg::cmsa_grant_e    grant;
   int                       error_cnt, samples_checked, cyc;
   int                       n [5];
   cmsa_arbiter u_dut (.*, .req({rq[6:1], host_req}));
   cmsa_host_model u_host (.clk(clk), .sys_rst(sys_rst), .enable(host_en), .slot_strobe(slot_strobe),
      .grant(grant), .host_req(host_req));
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   // grant is read in the second clock of its slot, where it is settled
   task automatic nxt;
      @(posedge clk iff slot_strobe);
      #1;
   endtask : nxt
   task automatic to(logic [7:0] s);
      do nxt; while (slot_index !== s);
   endtask : to
   function automatic logic [3:0] tk(logic [4:0] c);
      if (c[0]) return `CMSA_LINE_PIXEL_TICKS;
      return `CMSA_BLIT_MIN_TICKS + (c[3] ? `CMSA_BLIT_B_TICKS : 4'h0) + (c[2] && c[1] ? `CMSA_BLIT_CD_TICKS : 4'h0);
   endfunction : tk
   task automatic t_fixed;
      n = '{default: 0};
      rq = '0;
      rq.disk = 1;
      rq.audio = 1;
      rq.sprite = 1;
      to(8'h00);
      do begin
         nxt;
         n[0] += grant == cmsa_pkg::CMSA_GNT_REFRESH;
         n[1] += grant_fixed_disk;
         n[2] += grant_fixed_audio;
         n[3] += grant_fixed_sprite;
         n[4]++;
      end while (slot_index !== 8'h00);
      chk("refresh", `CMSA_REFRESH_SLOTS, n[0]);
      chk("disk", `CMSA_DISK_SLOTS, n[1]);
      chk("audio", `CMSA_AUDIO_SLOTS, n[2]);
      chk("sprite", `CMSA_SPRITE_SLOTS, n[3]);
      chk("line", 1, n[4] inside {227, 228});
   endtask : t_fixed
   task automatic t_offer;
      rq = '0;
      rq.coproc = 1;
      host_en = 1;
      to(8'h09);
      chk("free disk slot", cmsa_pkg::CMSA_GNT_COPROC, grant);
      to(8'h0A);
      chk("coproc over host", cmsa_pkg::CMSA_GNT_COPROC, grant);
      rq.coproc = 0;
      to(8'h0C);
      chk("host even", cmsa_pkg::CMSA_GNT_HOST, grant);
      nxt;
      chk("host odd", cmsa_pkg::CMSA_GNT_NONE, grant);
   endtask : t_offer
   task automatic t_plane;
      rq = '0;
      rq.plane = 1;
      rq.sprite = 1;
      rq.coproc = 1;
      plane_slot = 1;
      to(8'h17);
      chk("plane over sprite", cmsa_pkg::CMSA_GNT_PLANE, grant);
      n[0] = 0;
      repeat (60) begin
         nxt;
         n[0] += grant > cmsa_pkg::CMSA_GNT_PLANE;
      end
      chk("display lockout", 0, n[0]);
      plane_slot = 0;
   endtask : t_plane
   task automatic blit(logic [4:0] c);
      rq = '0;
      rq.blit = 1;
      n[0] = 0;
      blit_cfg = c;
      blit_start = 1;
      @(posedge clk);
      #1;
      blit_start = 0;
      chk("ticks", tk(c), blit_cycle_ticks);
      while (blit_busy) begin
         @(posedge clk);
         #1;
         n[0] += blit_cycle_done;
      end
      chk("cycles", blit_height * blit_width, n[0]);
   endtask : blit
   task automatic t_hog;
      host_en = 1;
      blit_bus_priority_bit = 1;
      blit_cfg = 5'h12;
      blit_height = 10'h0C8;
      blit_width = 6'h01;
      blit_start = 1;
      @(posedge clk);
      #1;
      blit_start = 0;
      nxt;
      n = '{default: 0};
      repeat (40) begin
         nxt;
         n[0] += grant == cmsa_pkg::CMSA_GNT_HOST;
      end
      chk("hog host", 0, n[0]);
      blit_bus_priority_bit = 0;
      nxt;
      repeat (40) begin
         nxt;
         n[1] += grant == cmsa_pkg::CMSA_GNT_HOST;
         n[2] += grant == cmsa_pkg::CMSA_GNT_BLIT;
      end
      chk("yield host", 1, n[1] > 0);
      chk("blit first", 1, n[2] > n[1]);
      while (blit_busy) @(posedge clk);
   endtask : t_hog
   task automatic complete_run;
      if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         complete_run;
      end
   end
   initial begin
      {sys_rst, rq, host_en, plane_slot, blit_bus_priority_bit, blit_cfg, blit_start} = '1;
      {rq, host_en, plane_slot, blit_bus_priority_bit, blit_cfg, blit_start} = '0;
      blit_height = 10'h002;
      blit_width = 6'h03;
      repeat (6) @(posedge clk);
      #1 sys_rst = 0;
      t_fixed;
      t_offer;
      t_plane;
      for (int i = 0; i < 32; i++) blit(i[4:0]);
      t_hog;
      complete_run;
   end
endmodule : chip_memory_slot_arbiter_tb
